// File: hw/rpm_pkg.sv
package rpm_pkg;

  // ****************************************************************
  // register map (byte addresses, one word each)
  // ****************************************************************
  // printed offset 0x87 is not a multiple of four: it is an index
  localparam logic [7:0]  PWRCTL_IDX    = 8'h87;
  localparam logic [11:0] PWRCTL_ADDR   = 12'h21c; // 4 * 0x87
  localparam logic [11:0] WDRESTART_ADDR = 12'h000;
  localparam logic [11:0] WDPROG_ADDR   = 12'h004;
  localparam logic [11:0] CONFIG_ADDR   = 12'h008;
  localparam logic [11:0] STATUS_ADDR   = 12'h00c;

  // power_control fields
  localparam int PC_IDLE  = 0;
  localparam int PC_PDOWN = 1;
  localparam int PC_POF   = 4;
  localparam int PC_POWERDOWN_EXIT_MODE = 5;
  localparam logic [7:0] PC_RESET = 8'h00;

  // watchdog_program_reg fields
  localparam int WP_DISRO = 0;
  localparam int WP_SOFTWARE_RESET_FLAG = 1;
  localparam int WP_WDOVF = 2;
  localparam int WP_WDIDL = 3;

  // sequence bytes
  localparam logic [7:0] SEQ_SW_A = 8'h5a;
  localparam logic [7:0] SEQ_SW_B = 8'ha5;
  localparam logic [7:0] SEQ_WD_A = 8'h1e;
  localparam logic [7:0] SEQ_WD_B = 8'he1;

  // reset vectors and fuse codes
  localparam logic [15:0] VEC_BOOT = 16'hf800;
  localparam logic [15:0] VEC_NORM = 16'h0000;
  localparam logic [7:0]  FUSE_00  = 8'h00;
  localparam logic [7:0]  FUSE_FF  = 8'hff;

  // pulse lengths in clock cycles
  localparam logic [5:0] CA_PULSE   = 6'h10; // 16
  localparam logic [5:0] SW_PULSE   = 6'h31; // 49
  localparam logic [5:0] WAKE_PULSE = 6'h02; // 2

  // start-up timer: 16 us at 20 MHz
  localparam int SUT_US     = 16;
  localparam int CLK_MHZ    = 20;
  localparam int SUT_CYCLES = SUT_US * CLK_MHZ;

  typedef enum logic [1:0] {
    RPM_PM_NORMAL,
    RPM_PM_LOW,
    RPM_PM_XLOW
  } rpm_pmode_e;

  typedef enum logic [2:0] {
    RPM_RUN,
    RPM_IDLE,
    RPM_PD,
    RPM_WAKE_TIMED,
    RPM_WAKE_EXT,
    RPM_WAKE_RST
  } rpm_state_e;

  // wake sources grouped together
  typedef struct packed {
    logic       irq0;
    logic       irq1;
    logic       irq0_en;
    logic       irq1_en;
    logic       irq0_type;
    logic       irq1_type;
    logic       kbd_en;
    logic [7:0] kbd_pin_en;
    logic [7:0] kbd_pins;
  } rpm_wake_s;

endpackage

// File: hw/rpm_top.sv
// Summary of operation
// - counter-array watchdog match gives a 16-cycle internal reset pulse
// - counter-array reset pulse never drives the reset pin
// - writing 5A then A5 to restart register gives 49-cycle reset
// - software sequence reset sets the software reset flag
// - any other sequence resets at once, sets overflow and software flags
// - software reset drives reset pin unless reset-output disable is set
// - start at F800 if boot fuse is 00 or store-enable pin low
// - idle stops the CPU clock, and the watchdog unless its idle bit is set; state and pins held
// - idle keeps peripherals and brown-out running; watchdog per idle bit
// - enabled level irq, enabled keypad pin or reset ends idle; interrupt serviced at once
// - hardware clears idle bit and power-down bit on wake
// - power-off flag set by cold reset, software writable, warm kept
// - power-down stops oscillator, brown-out and program memory
// - only level external irqs, enabled keypad pins or the reset pin end power-down
// - exit mode one: falling edge starts timer, clock held until timeout
// - exit mode zero: clock held until wake pin rises again
// - reset-pin wake runs timer; early release gives two-cycle reset
// - power mode chosen from two fuse bytes
// - writing 1E then E1 restarts the hardware watchdog
// - reset-output disable keeps internal pulses off the reset pin
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none

module rpm_top (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic               cold_reset,
  input  wire logic [11:0]        s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [11:0]        s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  input  wire logic               counter_array_match,
  input  wire rpm_pkg::rpm_wake_s wake,
  input  wire logic               reset_pin_active,
  input  wire logic               program_store_enable_pin,
  input  wire logic [7:0]         bootloader_jump_fuse,
  input  wire logic [7:0]         lp_fuse_one,
  input  wire logic [7:0]         lp_fuse_zero,
  output logic                    internal_reset,
  output logic                    reset_pin_o,
  output logic                    reset_pin_oe_n,
  output logic [15:0]             reset_vector,
  output logic                    cpu_clk_en,
  output logic                    osc_enable,
  output logic                    brownout_enable,
  output logic                    progmem_enable,
  output logic                    watchdog_run,
  output logic                    watchdog_restart,
  output logic                    wake_irq,
  output rpm_pkg::rpm_pmode_e     power_mode
);

  // ****************************************************************
  // state
  // ****************************************************************
  logic [7:0]          power_control_q;
  logic [3:0]          wprog_q;
  logic [7:0]          first_q;
  logic                have_first_q;
  logic [5:0]          pulse_cnt_q;
  logic                pulse_pin_q;
  logic [$clog2(rpm_pkg::SUT_CYCLES+1)-1:0] sut_cnt_q;
  rpm_pkg::rpm_state_e st_q;
  logic                early_rel_q;
  logic                reset_seen_q;
  logic                aw_hold_q;
  logic                w_hold_q;
  logic [11:0]         awaddr_q;
  logic [31:0]         wdata_q;
  logic [3:0]          wstrb_q;
  logic                irq0_d1_q;
  logic                irq1_d1_q;
  logic [7:0]          kbd_d1_q;

  // ****************************************************************
  // axi-lite write path
  // ****************************************************************
  logic wr_fire;
  logic [11:0] wr_addr;
  logic [31:0] wr_data;
  logic        wr_lane0;
  assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold_q && !s_axi_bvalid;
  assign wr_fire  = (aw_hold_q || (s_axi_awvalid && s_axi_awready)) &&
                    (w_hold_q || (s_axi_wvalid && s_axi_wready));
  assign wr_addr  = aw_hold_q ? awaddr_q : s_axi_awaddr;
  assign wr_data  = w_hold_q ? wdata_q : s_axi_wdata;
  assign wr_lane0 = w_hold_q ? wstrb_q[0] : s_axi_wstrb[0];

  // address and data may arrive in either order; each is held until both are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q    <= 1'b0;
      w_hold_q     <= 1'b0;
      awaddr_q     <= 12'h000;
      wdata_q      <= 32'h0000_0000;
      wstrb_q      <= 4'h0;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (wr_fire) begin
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end else begin
        if (s_axi_awvalid && s_axi_awready) begin
          aw_hold_q <= 1'b1;
          awaddr_q  <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          w_hold_q <= 1'b1;
          wdata_q  <= s_axi_wdata;
          wstrb_q  <= s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
          s_axi_bvalid <= 1'b0;
        end
      end
    end
  end

  // unmapped writes still answer okay; nothing stored
  assign s_axi_bresp = 2'b00;

  // decoded byte strobes for the power-control, restart and program registers
  logic wr_power_control;
  logic wr_rst;
  logic wr_prog;
  always_comb begin
    wr_power_control = 1'b0;
    wr_rst  = 1'b0;
    wr_prog = 1'b0;
    if (wr_fire && wr_lane0) begin
      if (wr_addr == rpm_pkg::PWRCTL_ADDR) begin
        wr_power_control = 1'b1;
      end else if (wr_addr == rpm_pkg::WDRESTART_ADDR) begin
        wr_rst = 1'b1;
      end else if (wr_addr == rpm_pkg::WDPROG_ADDR) begin
        wr_prog = 1'b1;
      end
    end
  end

  // ****************************************************************
  // reset sequence detector
  // ****************************************************************
  logic seq_sw;
  logic seq_wd;
  logic seq_bad;
  logic [7:0] wb;
  assign wb      = wr_data[7:0];
  // only the second of two back-to-back writes completes a sequence
  assign seq_sw  = wr_rst && have_first_q && first_q == rpm_pkg::SEQ_SW_A &&
                   wb == rpm_pkg::SEQ_SW_B;
  assign seq_wd  = wr_rst && have_first_q && first_q == rpm_pkg::SEQ_WD_A &&
                   wb == rpm_pkg::SEQ_WD_B;
  assign seq_bad = wr_rst && have_first_q && !seq_sw && !seq_wd;
  assign watchdog_restart = seq_wd;

  // first byte latch; any other register write breaks the pair
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      have_first_q <= 1'b0;
      first_q      <= 8'h00;
    end else if (wr_rst && !have_first_q) begin
      have_first_q <= 1'b1;
      first_q      <= wb;
    end else if (wr_fire) begin
      have_first_q <= 1'b0;
    end
  end

  // ****************************************************************
  // reset pulse generator
  // ****************************************************************
  logic pulse_active;
  assign pulse_active = pulse_cnt_q != 6'h00;

  // software pulses win over the shorter counter-array pulse
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pulse_cnt_q <= 6'h00;
      pulse_pin_q <= 1'b0;
    end else if (seq_sw || seq_bad) begin
      pulse_cnt_q <= rpm_pkg::SW_PULSE;
      pulse_pin_q <= !wprog_q[rpm_pkg::WP_DISRO];
    end else if (counter_array_match && !pulse_active) begin
      pulse_cnt_q <= rpm_pkg::CA_PULSE;
      pulse_pin_q <= 1'b0;
    end else if (st_q == rpm_pkg::RPM_WAKE_RST && sut_cnt_q == '0 && early_rel_q) begin
      pulse_cnt_q <= rpm_pkg::WAKE_PULSE;
      pulse_pin_q <= 1'b0;
    end else if (pulse_active) begin
      pulse_cnt_q <= pulse_cnt_q - 6'h01;
      if (pulse_cnt_q == 6'h01) begin
        pulse_pin_q <= 1'b0;
      end
    end
  end

  assign internal_reset = pulse_active || (st_q == rpm_pkg::RPM_WAKE_RST) ||
                          reset_pin_active;
  // open drain: enable low while driving
  assign reset_pin_o    = 1'b1;
  assign reset_pin_oe_n = !(pulse_active && pulse_pin_q);

  // ****************************************************************
  // watchdog program register and power control
  // ****************************************************************
  // flags set by hardware win over a software clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wprog_q <= 4'h0;
    end else begin
      if (wr_prog) begin
        wprog_q <= wr_data[3:0];
      end
      if (seq_sw || seq_bad) begin
        wprog_q[rpm_pkg::WP_SOFTWARE_RESET_FLAG] <= 1'b1;
      end
      if (seq_bad) begin
        wprog_q[rpm_pkg::WP_WDOVF] <= 1'b1;
      end
    end
  end

  logic wake_irq_pd;
  logic wake_idle;
  logic rst_rise;
  // ordinary reset keeps the power-off flag; cold reset sets it, a software write loads it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      power_control_q[3:0] <= 4'h0;
      power_control_q[7:5] <= 3'h0;
    end else begin
      if (wr_power_control) begin
        power_control_q[3:0] <= wr_data[3:0];
        power_control_q[7:5] <= wr_data[7:5];
      end
      if (wake_idle) begin
        power_control_q[rpm_pkg::PC_IDLE] <= 1'b0;
      end
      if (st_q == rpm_pkg::RPM_PD && (wake_irq_pd || rst_rise)) begin
        power_control_q[rpm_pkg::PC_PDOWN] <= 1'b0;
      end
    end
    // power-off flag sits outside the bus reset on purpose
    if (cold_reset) begin
      power_control_q[rpm_pkg::PC_POF] <= 1'b1;
    end else if (wr_power_control) begin
      power_control_q[rpm_pkg::PC_POF] <= wr_data[rpm_pkg::PC_POF];
    end
  end

  // ****************************************************************
  // wake detection
  // ****************************************************************
  logic       lvl0;
  logic       lvl1;
  logic [7:0] kbd_act;
  logic       irq_fall;
  logic       irq_low;
  assign lvl0 = wake.irq0_en && !wake.irq0_type;
  assign lvl1 = wake.irq1_en && !wake.irq1_type;
  assign kbd_act = wake.kbd_en ? (wake.kbd_pin_en & ~wake.kbd_pins) : 8'h00;
  assign irq_fall = (lvl0 && irq0_d1_q && !wake.irq0) ||
                    (lvl1 && irq1_d1_q && !wake.irq1) ||
                    ((kbd_act & kbd_d1_q) != 8'h00);
  assign irq_low  = (lvl0 && !wake.irq0) || (lvl1 && !wake.irq1) || (kbd_act != 8'h00);
  assign wake_irq_pd = irq_fall;
  assign rst_rise    = reset_pin_active && !reset_seen_q;
  assign wake_idle   = st_q == rpm_pkg::RPM_IDLE && (irq_low || reset_pin_active);

  // previous pin levels for edge detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq0_d1_q    <= 1'b1;
      irq1_d1_q    <= 1'b1;
      kbd_d1_q     <= 8'h00;
      reset_seen_q <= 1'b0;
    end else begin
      irq0_d1_q    <= wake.irq0;
      irq1_d1_q    <= wake.irq1;
      kbd_d1_q     <= ~(wake.kbd_pin_en & ~wake.kbd_pins);
      reset_seen_q <= reset_pin_active;
    end
  end

  // ****************************************************************
  // power mode state machine
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q        <= rpm_pkg::RPM_RUN;
      sut_cnt_q   <= '0;
      early_rel_q <= 1'b0;
    end else begin
      case (st_q)
        rpm_pkg::RPM_RUN: begin
          if (power_control_q[rpm_pkg::PC_PDOWN]) begin
            st_q <= rpm_pkg::RPM_PD;
          end else if (power_control_q[rpm_pkg::PC_IDLE]) begin
            st_q <= rpm_pkg::RPM_IDLE;
          end
        end
        rpm_pkg::RPM_IDLE: begin
          if (wake_idle) begin
            st_q <= rpm_pkg::RPM_RUN;
          end
        end
        rpm_pkg::RPM_PD: begin
          // timer length fixed; SUT_CYCLES is the only shortening point
          sut_cnt_q   <= ($clog2(rpm_pkg::SUT_CYCLES+1))'(rpm_pkg::SUT_CYCLES);
          early_rel_q <= 1'b0;
          if (rst_rise) begin
            st_q <= rpm_pkg::RPM_WAKE_RST;
          end else if (wake_irq_pd && power_control_q[rpm_pkg::PC_POWERDOWN_EXIT_MODE]) begin
            st_q <= rpm_pkg::RPM_WAKE_TIMED;
          end else if (wake_irq_pd) begin
            st_q <= rpm_pkg::RPM_WAKE_EXT;
          end
        end
        rpm_pkg::RPM_WAKE_TIMED: begin
          // pin level ignored while counting
          if (sut_cnt_q == '0) begin
            st_q <= rpm_pkg::RPM_RUN;
          end else begin
            sut_cnt_q <= sut_cnt_q - 1'b1;
          end
        end
        rpm_pkg::RPM_WAKE_EXT: begin
          if (!irq_low) begin
            st_q <= rpm_pkg::RPM_RUN;
          end
        end
        default: begin
          if (!reset_pin_active) begin
            early_rel_q <= 1'b1;
          end
          if (sut_cnt_q != '0) begin
            sut_cnt_q <= sut_cnt_q - 1'b1;
          end else if (early_rel_q || !reset_pin_active) begin
            st_q <= rpm_pkg::RPM_RUN;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // clock gating, vector and fuse outputs
  // ****************************************************************
  logic in_pd;
  assign in_pd = st_q == rpm_pkg::RPM_PD;
  assign cpu_clk_en      = st_q == rpm_pkg::RPM_RUN;
  assign osc_enable      = !in_pd;
  assign brownout_enable = !in_pd;
  assign progmem_enable  = !in_pd;
  assign watchdog_run    = st_q == rpm_pkg::RPM_RUN ||
                           (st_q == rpm_pkg::RPM_IDLE && wprog_q[rpm_pkg::WP_WDIDL]);
  // no interrupt logic of its own; wake requests go to the interrupt unit
  assign wake_irq        = 1'b0;

  // vector caught on the last cycle of internal reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reset_vector <= rpm_pkg::VEC_NORM;
    end else if (internal_reset) begin
      reset_vector <= (bootloader_jump_fuse == rpm_pkg::FUSE_00 || !program_store_enable_pin)
                      ? rpm_pkg::VEC_BOOT : rpm_pkg::VEC_NORM;
    end
  end

  always_comb begin
    if (lp_fuse_zero == rpm_pkg::FUSE_00) begin
      power_mode = rpm_pkg::RPM_PM_NORMAL;
    end else if (lp_fuse_one == rpm_pkg::FUSE_00) begin
      power_mode = rpm_pkg::RPM_PM_XLOW;
    end else begin
      power_mode = rpm_pkg::RPM_PM_LOW;
    end
  end

  // ****************************************************************
  // axi-lite read path
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      if (s_axi_araddr == rpm_pkg::PWRCTL_ADDR) begin
        s_axi_rdata <= {24'h000000, power_control_q};
      end else if (s_axi_araddr == rpm_pkg::WDPROG_ADDR) begin
        s_axi_rdata <= {28'h0000000, wprog_q};
      end else if (s_axi_araddr == rpm_pkg::STATUS_ADDR) begin
        s_axi_rdata <= {11'h000, reset_vector, power_mode, st_q};
      end else begin
        s_axi_rdata <= 32'h0000_0000;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  assign s_axi_arready = !s_axi_rvalid;
  assign s_axi_rresp   = 2'b00;

  // ****************************************************************
  // checks
  // ****************************************************************
  sequence sw_start_s;
    seq_sw;
  endsequence
  sequence pulse_hold_s;
    pulse_active [*8];
  endsequence

  sw_pulse_a: assert property (@(posedge aclk) disable iff (!aresetn)
    sw_start_s |=> pulse_cnt_q == 6'h31 ##1 pulse_hold_s)
    else $error("software reset pulse wrong length");
  ca_len_a: assert property (@(posedge aclk) disable iff (!aresetn)
    counter_array_match && !pulse_active && !seq_sw && !seq_bad && !(st_q == rpm_pkg::RPM_WAKE_RST)
    |=> pulse_cnt_q == 6'h10 ##15 pulse_cnt_q == 6'h01)
    else $error("counter array pulse wrong length");
  ca_pin_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(pulse_active) && $past(counter_array_match) && !$past(seq_sw) && !$past(seq_bad)
    |-> reset_pin_oe_n)
    else $error("counter array pulse on pin");
  bad_flags_a: assert property (@(posedge aclk) disable iff (!aresetn)
    seq_bad |=> wprog_q[rpm_pkg::WP_WDOVF] && wprog_q[rpm_pkg::WP_SOFTWARE_RESET_FLAG] && pulse_active)
    else $error("bad sequence flags missing");
  sw_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
    seq_sw |=> wprog_q[rpm_pkg::WP_SOFTWARE_RESET_FLAG])
    else $error("software flag not set");
  pin_drive_a: assert property (@(posedge aclk) disable iff (!aresetn)
    seq_sw && !wprog_q[rpm_pkg::WP_DISRO] && !wr_prog |=> !reset_pin_oe_n [*8])
    else $error("reset pin not driven");
  pd_osc_a: assert property (@(posedge aclk) disable iff (!aresetn)
    st_q == rpm_pkg::RPM_PD |-> !osc_enable && !brownout_enable && !cpu_clk_en)
    else $error("power-down left clocks on");
  timed_wake_a: assert property (@(posedge aclk) disable iff (!aresetn)
    st_q == rpm_pkg::RPM_PD ##1 st_q == rpm_pkg::RPM_WAKE_TIMED |-> !cpu_clk_en [*8])
    else $error("clock released early");
  idle_clr_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wake_idle && !wr_power_control |=> !power_control_q[rpm_pkg::PC_IDLE])
    else $error("idle bit not cleared");

endmodule // rpm_top

`default_nettype wire

// File: verif/reset_and_power_mode_control_bench.sv
`timescale 1ns/100ps
`default_nettype none

module reset_and_power_mode_control_bench;
  logic aclk = 0, aresetn = 0, cold_reset = 1;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'h1, cmd = 4'h0;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0] bootloader_jump_fuse = 8'hff, lp_fuse_one = 8'hff, lp_fuse_zero = 8'hff;
  rpm_pkg::rpm_wake_s wake;
  logic reset_pin_active, program_store_enable_pin, counter_array_match;
  logic internal_reset, reset_pin_o, reset_pin_oe_n, cpu_clk_en, osc_enable;
  logic brownout_enable, progmem_enable, watchdog_run, watchdog_restart, wake_irq;
  logic [15:0] reset_vector;
  rpm_pkg::rpm_pmode_e power_mode;
  int miscompares = 0, samples_checked = 0, nrst = 0, noe = 0, nwr = 0;
  typedef struct {
    logic [7:0] f1, f0, bj, a, b, pre, fl;
    rpm_pkg::rpm_pmode_e m;
    logic [15:0] v;
    int er, eo, ew;
  } rpm_row_s;
  rpm_row_s rows[4] = '{
    '{8'hff, 8'hff, 8'hff, 8'h5a, 8'ha5, 8'h00, 8'h02, rpm_pkg::RPM_PM_LOW, 16'h0000, 49, 49, 0},
    '{8'h00, 8'hff, 8'h00, 8'h5a, 8'h11, 8'h00, 8'h06, rpm_pkg::RPM_PM_XLOW, 16'hf800, 49, 49, 0},
    '{8'hff, 8'h00, 8'h00, 8'h1e, 8'he1, 8'h00, 8'h00, rpm_pkg::RPM_PM_NORMAL, 16'hf800, 0, 0, 1},
    '{8'h00, 8'h00, 8'hff, 8'h5a, 8'ha5, 8'h01, 8'h03, rpm_pkg::RPM_PM_NORMAL, 16'h0000, 49, 0, 0}};

  rpm_top dut_u (.*);
  rpm_far far_u (.*);

  initial forever #25 aclk = ~aclk;

  // pulse meters sample mid-cycle, clear of the launching edge
  always @(negedge aclk) begin
    nrst += (internal_reset === 1'b1);
    noe += (reset_pin_oe_n === 1'b0);
    nwr += (watchdog_restart === 1'b1);
  end

  task report_and_stop;
    if (miscompares == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask

  task cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // address and data offered together, each dropped when taken
  task wr(input logic [11:0] a, input logic [7:0] d);
    logic done;
    done = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    // ready stays up between transfers; the watchdog ends a hang
    while (!done) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_bvalid) done = 1;
    end
  endtask

  task rdr(input logic [11:0] a);
    logic done;
    done = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    while (!done) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rvalid) begin
        rd = s_axi_rdata;
        done = 1;
      end
    end
  endtask

  // pin pulse through the far side
  task pin(input logic [3:0] c, input int n);
    cmd <= c;
    cyc(n);
    cmd <= 4'h0;
    cyc(6);
  endtask

  initial begin
    cyc(4);
    aresetn <= 1;
    cold_reset <= 0;
    cyc(1);
    rdr(rpm_pkg::PWRCTL_ADDR);
    chk("power_control", 32'h10, rd);
    rdr(12'h010);
    chk("unmapped", 32'h0, rd);
    foreach (rows[i]) begin
      lp_fuse_one <= rows[i].f1;
      lp_fuse_zero <= rows[i].f0;
      bootloader_jump_fuse <= rows[i].bj;
      wr(rpm_pkg::WDPROG_ADDR, rows[i].pre);
      nrst = 0;
      noe = 0;
      nwr = 0;
      wr(rpm_pkg::WDRESTART_ADDR, rows[i].a);
      wr(rpm_pkg::WDRESTART_ADDR, rows[i].b);
      cyc(80);
      chk("reset cycles", rows[i].er, nrst);
      chk("pin drive cycles", rows[i].eo, noe);
      chk("restart pulses", rows[i].ew, nwr);
      rdr(rpm_pkg::WDPROG_ADDR);
      chk("program flags", {24'h0, rows[i].fl}, rd);
      chk("vector", {16'h0, rows[i].v}, {16'h0, reset_vector});
      chk("power mode", {30'h0, rows[i].m}, {30'h0, power_mode});
    end
    wr(rpm_pkg::WDPROG_ADDR, 8'h00);
    nrst = 0;
    noe = 0;
    pin(4'h8, 1);
    cyc(30);
    chk("match reset cycles", 16, nrst);
    chk("match pin drive", 0, noe);
    chk("pin level", 1, reset_pin_o);
    chk("responses", 0, {s_axi_bresp, s_axi_rresp, wake_irq});
    pin(4'h6, 3);
    chk("boot vector", 32'hf800, {16'h0, reset_vector});
    pin(4'h2, 3);
    chk("normal vector", 32'h0, {16'h0, reset_vector});
    wr(rpm_pkg::PWRCTL_ADDR, 8'h01);
    cyc(3);
    chk("idle cpu clock", 0, cpu_clk_en);
    chk("idle brownout", 1, brownout_enable & osc_enable);
    chk("idle watchdog", 0, watchdog_run);
    pin(4'h2, 2);
    chk("idle exit", 1, cpu_clk_en);
    rdr(rpm_pkg::PWRCTL_ADDR);
    chk("idle bit clear", 32'h0, rd);
    wr(rpm_pkg::PWRCTL_ADDR, 8'h22);
    cyc(3);
    chk("pd supplies", 0, osc_enable | brownout_enable | progmem_enable);
    pin(4'h1, 3);
    cyc(284);
    chk("timed wake held", 0, cpu_clk_en);
    cyc(60);
    chk("timed wake done", 1, cpu_clk_en);
    rdr(rpm_pkg::PWRCTL_ADDR);
    chk("pd bit clear", 32'h20, rd);
    wr(rpm_pkg::PWRCTL_ADDR, 8'h02);
    cyc(3);
    cmd <= 4'h1;
    cyc(400);
    chk("external wake held", 0, cpu_clk_en);
    cmd <= 4'h0;
    cyc(6);
    chk("external wake done", 1, cpu_clk_en);
    // reset pin wake, released long before the start-up timer ends
    wr(rpm_pkg::PWRCTL_ADDR, 8'h02);
    cyc(3);
    pin(4'h2, 3);
    cyc(300);
    chk("reset wake held", 0, cpu_clk_en);
    wait (cpu_clk_en === 1'b1);
    nrst = 0;
    cyc(10);
    chk("reset wake pulse", 2, nrst);
    // bus reset in mid-run keeps the power-off flag
    wr(rpm_pkg::PWRCTL_ADDR, 8'h10);
    aresetn <= 0;
    cyc(2);
    aresetn <= 1;
    cyc(1);
    chk("run after reset", 1, cpu_clk_en);
    rdr(rpm_pkg::PWRCTL_ADDR);
    chk("power-off kept", 32'h10, rd);
    report_and_stop();
  end

  // hang guard: the whole sequence needs about 1600 cycles
  initial begin
    #300000;
    miscompares++;
    report_and_stop();
  end
endmodule // reset_and_power_mode_control_bench

`default_nettype wire

// File: verif/rpm_far.sv
`timescale 1ns/100ps
`default_nettype none

// far side: board reset pin, store-enable pin and wake pins
module rpm_far (
  input  wire logic         aclk,
  input  wire logic [3:0]   cmd,
  output rpm_pkg::rpm_wake_s wake,
  output logic              reset_pin_active,
  output logic              program_store_enable_pin,
  output logic              counter_array_match
);
  // cmd: 0 irq0 low, 1 reset pin, 2 store pin low, 3 match
  always_ff @(posedge aclk) begin
    wake <= '{irq0: !cmd[0], irq1: 1'b1, irq0_en: 1'b1, irq1_en: 1'b0,
      irq0_type: 1'b0, irq1_type: 1'b0, kbd_en: 1'b0,
      kbd_pin_en: 8'h00, kbd_pins: 8'hff};
    reset_pin_active <= cmd[1];
    program_store_enable_pin <= !cmd[2];
    counter_array_match <= cmd[3];
  end
endmodule // rpm_far

`default_nettype wire
